/* File: verilog/cmpl_pkg.sv */
/*
 * constants, field positions, reset values and carrier types for the
 * comparator output latch logic block.
 * assumes a single 10 MHz clock and a classic wishbone master with 32-bit data.
 */
// What this block does
// - comparator result reaches its pin only when on, pin enabled, direction bit 0
// - gate select 0 drives the timer gate from the synchronised comparator 2 result
// - gate select 1 uses the external gate pin; the bit resets to 1
// - sync enable set captures comparator 2 on the timer clock falling edge
// - sync enable clear passes comparator 2 through without capture
// - capture uses the prescaled timer clock, not the raw source
// - timer counts on rising edge, capture on falling edge, avoiding a race
// - status register bits 7 and 6 mirror both comparator results, read-only
// - reading the mirror bits has no side effect on interrupt mismatch state
// - mirror register bits 5 to 2 are unimplemented and read 0
// - latch is sampled each clock, active-high inputs; comparator 1 or pulse_set sets it
// - comparator 2 result or a pulse_reset write resets the latch
// - set and reset together leave the latch reset
// - pulse bits are set-only, fire one pulse, clear themselves; 0 ignored
// - two route bits pick one of four pin pairings
// - after reset the pins carry the raw comparator results
// - routing works whether or not the comparators are on
package cmpl_pkg;

	localparam int CLK_HZ = 10000000;
	localparam int ADR_W  = 4;

	// register byte addresses
	localparam logic [3:0] MIRROR_GATE_OFS = 4'h0;
	localparam logic [3:0] LATCH_CTRL_OFS  = 4'h4;

	// comparator_mirror_gate_control fields
	localparam int MIRROR_C1_BIT = 7;
	localparam int MIRROR_C2_BIT = 6;
	localparam int GATE_SEL_BIT  = 1;
	localparam int SYNC_EN_BIT   = 0;
	localparam logic GATE_SEL_RST = 1'b1;
	localparam logic SYNC_EN_RST  = 1'b0;

	// set_reset_latch_control fields
	localparam int ROUTE_HI_BIT = 7;
	localparam int ROUTE_LO_BIT = 6;
	localparam int C1_SET_BIT   = 5;
	localparam int C2_RST_BIT   = 4;
	localparam int PULSE_S_BIT  = 3;
	localparam int PULSE_R_BIT  = 2;
	localparam logic ROUTE_RST  = 1'b0;
	localparam logic LATCH_EN_RST = 1'b0;

	typedef struct packed {
		logic c1_out;
		logic c1_oe;
		logic c2_out;
		logic c2_oe;
	} cmpl_pins_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
		logic        gate_sel;
		logic        sync_en;
		logic        route_hi;
		logic        route_lo;
		logic        c1_set_en;
		logic        c2_rst_en;
		logic        pulse_s;
		logic        pulse_r;
		logic        latch_q;
		logic        tclk_prev;
		logic        synced_c2;
		logic        gate;
		cmpl_pins_t  pins;
	} cmpl_state_t;

endpackage

/* File: verilog/cmpl_top.sv */
/*
 * comparator output latch logic: timer gate source and comparator 2 capture,
 * mirror status register, reset-dominant set/reset latch and pin multiplexers.
 * assumes comparator results, enables and the prescaled timer clock arrive
 * synchronous to clk; the timer counter and port drivers live outside.
 */
// The address map and the Wishbone slave port were chosen for this implementation.
module cmpl_top (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [cmpl_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic                     comp1_result,
	input  wire logic                     comp2_result,
	input  wire logic                     comp1_on,
	input  wire logic                     comp2_on,
	input  wire logic                     comp1_pin_enable,
	input  wire logic                     comp2_pin_enable,
	input  wire logic [1:0]               pin_direction_bit,
	input  wire logic                     timer_clk_prescaled,
	input  wire logic                     external_gate_pin,
	output logic                          timer_gate,
	output logic                          synced_comp2_result,
	output logic                          latch_q,
	output cmpl_pkg::cmpl_pins_t          pins
);

	cmpl_pkg::cmpl_state_t s;
	cmpl_pkg::cmpl_state_t next_s;

	logic set_in;
	logic rst_in;
	logic wr_mirror;
	logic wr_latch;
	logic c1_path;
	logic c2_path;

	function automatic logic hit(input logic [cmpl_pkg::ADR_W-1:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus access and register state

	always_comb begin
		next_s = s;
		wr_mirror = 1'b0;
		wr_latch = 1'b0;
		next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
		next_s.dat = 32'h0;
		// pulses live for exactly one clock
		next_s.pulse_s = 1'b0;
		next_s.pulse_r = 1'b0;
		if (next_s.ack) begin
			// reads are free of side effects, mismatch state stays outside
			if (hit(wb_adr_i, cmpl_pkg::MIRROR_GATE_OFS)) begin
				next_s.dat[cmpl_pkg::MIRROR_C1_BIT] = comp1_result;
				next_s.dat[cmpl_pkg::MIRROR_C2_BIT] = comp2_result;
				next_s.dat[cmpl_pkg::GATE_SEL_BIT] = s.gate_sel;
				next_s.dat[cmpl_pkg::SYNC_EN_BIT] = s.sync_en; // bits 5..2 stay 0
			end else if (hit(wb_adr_i, cmpl_pkg::LATCH_CTRL_OFS)) begin
				next_s.dat[cmpl_pkg::ROUTE_HI_BIT] = s.route_hi;
				next_s.dat[cmpl_pkg::ROUTE_LO_BIT] = s.route_lo;
				next_s.dat[cmpl_pkg::C1_SET_BIT] = s.c1_set_en;
				next_s.dat[cmpl_pkg::C2_RST_BIT] = s.c2_rst_en;
			end
		end
		// writes commit on the edge where the master sees ack
		if (wb_cyc_i && wb_stb_i && s.ack && wb_we_i && wb_sel_i[0]) begin
			if (hit(wb_adr_i, cmpl_pkg::MIRROR_GATE_OFS)) begin
				wr_mirror = 1'b1;
			end else if (hit(wb_adr_i, cmpl_pkg::LATCH_CTRL_OFS)) begin
				wr_latch = 1'b1;
			end
		end
		if (wr_mirror) begin
			next_s.gate_sel = wb_dat_i[cmpl_pkg::GATE_SEL_BIT];
			next_s.sync_en = wb_dat_i[cmpl_pkg::SYNC_EN_BIT];
		end
		if (wr_latch) begin
			next_s.route_hi = wb_dat_i[cmpl_pkg::ROUTE_HI_BIT];
			next_s.route_lo = wb_dat_i[cmpl_pkg::ROUTE_LO_BIT];
			next_s.c1_set_en = wb_dat_i[cmpl_pkg::C1_SET_BIT];
			next_s.c2_rst_en = wb_dat_i[cmpl_pkg::C2_RST_BIT];
			// writing 0 leaves the generators idle
			next_s.pulse_s = wb_dat_i[cmpl_pkg::PULSE_S_BIT];
			next_s.pulse_r = wb_dat_i[cmpl_pkg::PULSE_R_BIT];
		end

		////////////////////////////////////////////////////////////////////
		// comparator 2 capture and timer gate

		// the timer clock input is already past the prescaler
		next_s.tclk_prev = timer_clk_prescaled;
		if (!s.sync_en) begin
			next_s.synced_c2 = comp2_result;
		end else if (s.tclk_prev && !timer_clk_prescaled) begin
			// falling edge capture; timer counts on the rising edge
			next_s.synced_c2 = comp2_result;
		end
		next_s.gate = s.gate_sel ? external_gate_pin : s.synced_c2;

		////////////////////////////////////////////////////////////////////
		// reset-dominant latch, sampled each clock rather than truly clockless

		set_in = (s.c1_set_en & comp1_result) | s.pulse_s;
		rst_in = (s.c2_rst_en & comp2_result) | s.pulse_r;
		if (rst_in) begin
			next_s.latch_q = 1'b0;
		end else if (set_in) begin
			next_s.latch_q = 1'b1;
		end

		////////////////////////////////////////////////////////////////////
		// pin multiplexers; latch paths ignore comparator enables

		c1_path = s.route_lo ? s.latch_q : comp1_result;
		c2_path = s.route_hi ? ~s.latch_q : comp2_result;
		next_s.pins.c1_out = c1_path;
		next_s.pins.c2_out = c2_path;
		next_s.pins.c1_oe = comp1_pin_enable & ~pin_direction_bit[0] & (s.route_lo | comp1_on);
		next_s.pins.c2_oe = comp2_pin_enable & ~pin_direction_bit[1] & (s.route_hi | comp2_on);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.gate_sel <= cmpl_pkg::GATE_SEL_RST;
			s.sync_en <= cmpl_pkg::SYNC_EN_RST;
			s.route_hi <= cmpl_pkg::ROUTE_RST;
			s.route_lo <= cmpl_pkg::ROUTE_RST;
			s.c1_set_en <= cmpl_pkg::LATCH_EN_RST;
			s.c2_rst_en <= cmpl_pkg::LATCH_EN_RST;
		end else begin
			s <= next_s;
		end
	end

	assign wb_ack_o = s.ack;
	assign wb_dat_o = s.dat;
	assign timer_gate = s.gate;
	assign synced_comp2_result = s.synced_c2;
	assign latch_q = s.latch_q;
	assign pins = s.pins;

	////////////////////////////////////////////////////////////////////////
	// assertions

	a_pin1_gated: assert property (@(posedge clk) disable iff (!rst_n)
		(pin_direction_bit[0] || !comp1_pin_enable) |=> !pins.c1_oe)
		else $error("comparator 1 pin driven while direction or enable forbids");

	a_gate_from_comp: assert property (@(posedge clk) disable iff (!rst_n)
		!s.gate_sel |=> timer_gate == $past(s.synced_c2))
		else $error("timer gate does not follow synced comparator 2");

	a_gate_from_pin: assert property (@(posedge clk) disable iff (!rst_n)
		s.gate_sel |=> timer_gate == $past(external_gate_pin))
		else $error("timer gate does not follow external gate pin");

	a_sync_capture: assert property (@(posedge clk) disable iff (!rst_n)
		(s.sync_en && s.tclk_prev && !timer_clk_prescaled) |=> synced_comp2_result == $past(comp2_result))
		else $error("comparator 2 not captured on falling timer edge");

	a_sync_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(s.sync_en && !(s.tclk_prev && !timer_clk_prescaled)) |=> $stable(synced_comp2_result))
		else $error("synced comparator 2 changed without a falling edge");

	a_async_pass: assert property (@(posedge clk) disable iff (!rst_n)
		!s.sync_en |=> synced_comp2_result == $past(comp2_result))
		else $error("comparator 2 not passed through");

	a_mirror_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(wb_ack_o && !$past(wb_we_i)) |-> wb_dat_o[5:2] == 4'h0 || $past(wb_adr_i) != cmpl_pkg::MIRROR_GATE_OFS)
		else $error("unimplemented mirror bits read nonzero");

	a_reset_wins: assert property (@(posedge clk) disable iff (!rst_n)
		((s.pulse_r || (s.c2_rst_en && comp2_result)) && (s.pulse_s || comp1_result)) |=> !latch_q)
		else $error("latch not reset when set and reset coincide");

	a_pulse_clear: assert property (@(posedge clk) disable iff (!rst_n)
		s.pulse_s |=> !s.pulse_s && (latch_q || $past(s.pulse_r || (s.c2_rst_en && comp2_result))))
		else $error("set pulse did not clear or did not set the latch");

	a_route_lo: assert property (@(posedge clk) disable iff (!rst_n)
		s.route_lo |=> pins.c1_out == $past(s.latch_q))
		else $error("comparator 1 pin does not carry latch output");

	////////////////////////////////////////////////////////////////////////
	// pin enables and routing

	a_pin2_gated: assert property (@(posedge clk) disable iff (!rst_n)
		(pin_direction_bit[1] || !comp2_pin_enable) |=>
		!pins.c2_oe)
		else $error("comparator 2 pin driven while direction or enable forbids");

	a_pin1_off: assert property (@(posedge clk) disable iff (!rst_n)
		(!s.route_lo && !comp1_on) |=>
		!pins.c1_oe)
		else $error("comparator 1 pin driven while comparator 1 is off");

	a_pin2_off: assert property (@(posedge clk) disable iff (!rst_n)
		(!s.route_hi && !comp2_on) |=>
		!pins.c2_oe)
		else $error("comparator 2 pin driven while comparator 2 is off");

	a_pin1_drives: assert property (@(posedge clk) disable iff (!rst_n)
		(comp1_pin_enable && !pin_direction_bit[0] && comp1_on) |=>
		pins.c1_oe)
		else $error("comparator 1 pin not driven although all enables are set");

	a_pin2_drives: assert property (@(posedge clk) disable iff (!rst_n)
		(comp2_pin_enable && !pin_direction_bit[1] && comp2_on) |=>
		pins.c2_oe)
		else $error("comparator 2 pin not driven although all enables are set");

	a_latch_oe1: assert property (@(posedge clk) disable iff (!rst_n)
		(s.route_lo && comp1_pin_enable && !pin_direction_bit[0]) |=>
		pins.c1_oe)
		else $error("latch route on pin 1 blocked by comparator enable");

	a_latch_oe2: assert property (@(posedge clk) disable iff (!rst_n)
		(s.route_hi && comp2_pin_enable && !pin_direction_bit[1]) |=>
		pins.c2_oe)
		else $error("latch route on pin 2 blocked by comparator enable");

	a_route_hi: assert property (@(posedge clk) disable iff (!rst_n)
		s.route_hi |=>
		pins.c2_out == !$past(s.latch_q))
		else $error("comparator 2 pin does not carry inverted latch output");

	a_raw_c1: assert property (@(posedge clk) disable iff (!rst_n)
		!s.route_lo |=>
		pins.c1_out == $past(comp1_result))
		else $error("comparator 1 pin does not carry comparator 1 result");

	a_raw_c2: assert property (@(posedge clk) disable iff (!rst_n)
		!s.route_hi |=>
		pins.c2_out == $past(comp2_result))
		else $error("comparator 2 pin does not carry comparator 2 result");

	////////////////////////////////////////////////////////////////////////
	// state right after reset release

	a_reset_route: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |->
		(!s.route_hi && !s.route_lo))
		else $error("routing not raw comparator results after reset");

	a_reset_gate_sel: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |->
		(s.gate_sel && !s.sync_en))
		else $error("gate select or sync enable wrong after reset");

	a_reset_enables: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |->
		(!s.c1_set_en && !s.c2_rst_en))
		else $error("latch comparator enables not clear after reset");

	////////////////////////////////////////////////////////////////////////
	// register reads

	a_mirror_c1: assert property (@(posedge clk) disable iff (!rst_n)
		(wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == cmpl_pkg::MIRROR_GATE_OFS) |->
		wb_dat_o[cmpl_pkg::MIRROR_C1_BIT] == $past(comp1_result))
		else $error("mirror bit does not show comparator 1 result");

	a_mirror_c2: assert property (@(posedge clk) disable iff (!rst_n)
		(wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == cmpl_pkg::MIRROR_GATE_OFS) |->
		wb_dat_o[cmpl_pkg::MIRROR_C2_BIT] == $past(comp2_result))
		else $error("mirror bit does not show comparator 2 result");

	a_gate_sel_read: assert property (@(posedge clk) disable iff (!rst_n)
		(wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == cmpl_pkg::MIRROR_GATE_OFS) |->
		wb_dat_o[cmpl_pkg::GATE_SEL_BIT] == $past(s.gate_sel))
		else $error("gate select reads back wrong");

	a_latch_rd_low: assert property (@(posedge clk) disable iff (!rst_n)
		(wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == cmpl_pkg::LATCH_CTRL_OFS) |->
		wb_dat_o[3:0] == 4'h0)
		else $error("pulse or unused latch control bits read nonzero");

	a_read_no_effect: assert property (@(posedge clk) disable iff (!rst_n)
		(wb_ack_o && !wb_we_i) |=>
		$stable(s.gate_sel) && $stable(s.sync_en) && $stable({s.route_hi, s.route_lo, s.c1_set_en, s.c2_rst_en}))
		else $error("register read changed control state");

	////////////////////////////////////////////////////////////////////////
	// latch behaviour

	a_pulse_r_clear: assert property (@(posedge clk) disable iff (!rst_n)
		s.pulse_r |=>
		(!s.pulse_r && !latch_q))
		else $error("reset pulse did not clear or did not reset the latch");

	a_comp2_resets: assert property (@(posedge clk) disable iff (!rst_n)
		(s.c2_rst_en && comp2_result) |=>
		!latch_q)
		else $error("comparator 2 did not reset the latch");

	a_comp1_sets: assert property (@(posedge clk) disable iff (!rst_n)
		(s.c1_set_en && comp1_result && !s.pulse_r && !(s.c2_rst_en && comp2_result)) |=>
		latch_q)
		else $error("comparator 1 did not set the latch");

	a_pulse_sets: assert property (@(posedge clk) disable iff (!rst_n)
		(s.pulse_s && !s.pulse_r && !(s.c2_rst_en && comp2_result)) |=>
		latch_q)
		else $error("set pulse did not set the latch");

	a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(!s.pulse_s && !s.pulse_r && !(s.c1_set_en && comp1_result) && !(s.c2_rst_en && comp2_result)) |=>
		$stable(latch_q))
		else $error("latch changed with no set or reset input");

	a_set_masked: assert property (@(posedge clk) disable iff (!rst_n)
		(!s.c1_set_en && !s.pulse_s && !latch_q) |=>
		!latch_q)
		else $error("latch set while comparator 1 set path is disabled");

	a_reset_masked: assert property (@(posedge clk) disable iff (!rst_n)
		(!s.c2_rst_en && !s.pulse_r && latch_q) |=>
		latch_q)
		else $error("latch reset while comparator 2 reset path is disabled");

	////////////////////////////////////////////////////////////////////////
	// register writes and comparator 2 capture

	a_pulse_arm: assert property (@(posedge clk) disable iff (!rst_n)
		(wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == cmpl_pkg::LATCH_CTRL_OFS &&
		wb_dat_i[cmpl_pkg::PULSE_S_BIT]) |=> s.pulse_s)
		else $error("set pulse not fired by a write of one");

	a_pulse_s_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!(wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_dat_i[cmpl_pkg::PULSE_S_BIT]) |=>
		!s.pulse_s)
		else $error("set pulse fired without a write of one");

	a_pulse_r_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!(wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_dat_i[cmpl_pkg::PULSE_R_BIT]) |=>
		!s.pulse_r)
		else $error("reset pulse fired without a write of one");

	a_gate_sel_write: assert property (@(posedge clk) disable iff (!rst_n)
		(wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == cmpl_pkg::MIRROR_GATE_OFS) |=>
		s.gate_sel == $past(wb_dat_i[cmpl_pkg::GATE_SEL_BIT]))
		else $error("gate select write did not land");

	a_sync_en_write: assert property (@(posedge clk) disable iff (!rst_n)
		(wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == cmpl_pkg::MIRROR_GATE_OFS) |=>
		s.sync_en == $past(wb_dat_i[cmpl_pkg::SYNC_EN_BIT]))
		else $error("sync enable write did not land");

	a_route_write: assert property (@(posedge clk) disable iff (!rst_n)
		(wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == cmpl_pkg::LATCH_CTRL_OFS) |=>
		s.route_hi == $past(wb_dat_i[cmpl_pkg::ROUTE_HI_BIT]) && s.route_lo == $past(wb_dat_i[cmpl_pkg::ROUTE_LO_BIT]))
		else $error("route bits write did not land");

	a_tclk_sample: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=>
		s.tclk_prev == $past(timer_clk_prescaled))
		else $error("prescaled timer clock sample lost");

	a_no_rise_capture: assert property (@(posedge clk) disable iff (!rst_n)
		(s.sync_en && !s.tclk_prev && timer_clk_prescaled) |=>
		$stable(synced_comp2_result))
		else $error("comparator 2 captured on a rising timer edge");

endmodule

/* File: sim/cmpl_timer_model.sv */
/* timer_one model: prescaled timer clock and a gated counter.
   assumes the bench raises run only while a gate test is under way. */
module cmpl_timer_model (
	input  wire logic       clk,
	input  wire logic       run,
	input  wire logic       timer_gate,
	output logic            tclk,
	output logic [7:0]      count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div;
	initial begin
		tclk = 1'b1;
		div = 2'h0;
		count = 8'h00;
	end
	// clock stands still at its last level while run is low
	always @(posedge clk) begin
		if (run) begin
			div <= div + 2'h1;
			if (div == 2'h3) tclk <= ~tclk;
		end
	end
	// counts on the rising edge; the capture uses the falling one
	always @(posedge tclk) begin
		if (timer_gate) count <= count + 8'h01;
	end
endmodule

/* File: sim/cmpl_top_tb_top.sv */
/* self-checking bench for the comparator output latch logic.
   assumes the design answers every wishbone request within 50 cycles. */
module cmpl_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, c1 = 0, c2 = 0, on1 = 0, on2 = 0;
	logic en1 = 0, en2 = 0, ext = 0, run = 0, q = 0, ack, tclk, gate, syn, lq;
	logic [1:0] dir = 2'h3;
	logic [3:0] adr = 4'h0;
	logic [31:0] dw = 0, dr;
	logic [7:0] r, lc = 0, mg, cnt, cnt0;
	logic [7:0] corner [3] = '{8'h08, 8'h0c, 8'h3c};
	cmpl_pkg::cmpl_pins_t pins;
	int errors = 0, n_checks = 0, cycles = 0, seed;
	always #50 clk = ~clk;
	cmpl_top i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.comp1_result(c1), .comp2_result(c2), .comp1_on(on1), .comp2_on(on2),
		.comp1_pin_enable(en1), .comp2_pin_enable(en2), .pin_direction_bit(dir),
		.timer_clk_prescaled(tclk), .external_gate_pin(ext), .timer_gate(gate),
		.synced_comp2_result(syn), .latch_q(lq), .pins(pins));
	cmpl_timer_model i_tmr (.clk(clk), .run(run), .timer_gate(gate), .tclk(tclk), .count(cnt));
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dw <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) chk(8'h01, 8'h00);
		r = dr[7:0];
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic settle(int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic step(logic qi, logic ps, logic pr);
		return ((c2 & lc[4]) | pr) ? 1'b0 : ((c1 & lc[5]) | ps) ? 1'b1 : qi;
	endfunction
	function automatic logic [3:0] exp_pins();
		logic o1, o2;
		o1 = en1 & ~dir[0] & (lc[6] | on1);
		o2 = en2 & ~dir[1] & (lc[7] | on2);
		return {(lc[6] ? q : c1), o1, (lc[7] ? ~q : c2), o2};
	endfunction
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			errors++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = $urandom(32'h998f);
		settle(6);
		rst_n <= 1;
		wb(0, 4'h0, 8'h00);
		chk(r, 8'h02);
		wb(0, 4'h4, 8'h00);
		chk(r, 8'h00);
		wb(0, 4'h8, 8'h00);
		chk(r, 8'h00);
		{c1, on1, on2, en1, en2, dir} <= 7'h7c;
		settle(4);
		chk(pins, 8'h0d);
		$display("reset test done");
		for (int i = 0; i < 40; i++) begin
			{c1, c2, on1, on2, en1, en2, dir, ext} <= 9'($urandom);
			settle(4);
			q = step(q, 0, 0);
			lc = (i < 3) ? corner[i] : {i[1:0], 6'($urandom) & 6'h3c};
			mg = 8'($urandom) & 8'h03;
			wb(1, 4'h4, lc);
			wb(1, 4'h0, mg);
			settle(4);
			q = step(step(step(q, 0, 0), lc[3], lc[2]), 0, 0);
			lc[3:2] = 2'h0;
			chk(lq, q);
			chk(pins, exp_pins());
			wb(0, 4'h4, 8'h00);
			chk(r, lc);
			wb(0, 4'h0, 8'h00);
			chk(r, {c1, c2, 4'h0, mg[1:0]});
			if (mg[1]) chk(gate, ext);
			else if (!mg[0]) chk(gate, c2);
		end
		$display("random latch test done");
		rst_n <= 0;
		settle(2);
		rst_n <= 1;
		q = 0;
		lc = 8'h00;
		wb(0, 4'h4, 8'h00);
		chk(r, 8'h00);
		wb(0, 4'h0, 8'h00);
		chk(r, {c1, c2, 6'h02});
		settle(2);
		chk(pins, exp_pins());
		$display("mid-run reset test done");
		c2 <= 0;
		wb(1, 4'h0, 8'h00);
		settle(4);
		wb(1, 4'h0, 8'h01);
		c2 <= 1;
		settle(4);
		chk(syn, 8'h00);
		run <= 1;
		settle(12);
		chk(syn, 8'h01);
		cnt0 = cnt;
		settle(40);
		chk(cnt > cnt0, 8'h01);
		c2 <= 0;
		settle(16);
		cnt0 = cnt;
		settle(40);
		chk(cnt, cnt0);
		run <= 0;
		$display("gate sync test done");
		give_verdict();
	end
endmodule
